// ### hdl/flash_self_program_ctrl.sv
// flash self-programming controller: control register, arming windows, fuse/lock reads
//
// Operation
// - eeprom write busy blocks flash programming
// - eeprom write busy blocks fuse/lock reads
// - software checks eeprom busy before control write
// - pointer 0001 armed load returns lock byte
// - arming bits self-clear after read or timeout
// - unarmed load is ordinary flash read
// - pointer 0000 armed load returns fuse low
// - pointer 0003 armed load returns fuse high
// - programmed bits read zero, unprogrammed one
// - system reset never aborts running flash write
// - erase, write, lock write timed 3.7-4.5ms
// - boot size bits select boot region start
// - words below 3800 are read-while-write region
// - six low counter bits select page word
// - page from z14:z7, word from z6:z1
// - software zeroes word select on page write
// - z15 ignored, z0 is load byte select
// - read-while-write region unreadable while programming
// - software waits store enable, eeprom clear first
// - software repeats restore until region not busy (host issues restore once and does not recheck)
// - control register bit layout, reset zero
// - region busy set on program, cleared restore/load
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_ctrl
    import spm_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_MIN_CYCLES
)(
    input wire logic pclk,
    input wire logic presetn,
    spm_if.flash core,
    input wire logic ee_write_busy,
    input wire logic [7:0] fuse_low_prog,
    input wire logic [7:0] fuse_high_prog,
    input wire logic [7:0] lock_prog,
    output logic [PC_W-1:0] flash_raddr,
    input wire logic [15:0] flash_rdata,
    output logic buf_wr,
    output logic [WORD_SEL_W-1:0] buf_word,
    output logic [15:0] buf_wdata,
    output logic buf_clear,
    output logic prog_start,
    output logic prog_erase,
    output logic prog_lock,
    output logic [PAGE_SEL_W-1:0] prog_page,
    output logic [7:0] prog_lock_data,
    output logic prog_busy,
    output logic region_busy,
    output logic [PC_W-1:0] boot_start,
    output logic ready_irq
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [2:0] win;
        logic pend;
        logic from_flash;
        logic byte_hi;
        logic [7:0] direct;
        logic [PC_W-1:0] raddr;
        logic [7:0] load_data;
        logic load_valid;
        logic buf_wr;
        logic [WORD_SEL_W-1:0] buf_word;
        logic [15:0] buf_wdata;
        logic buf_clear;
        logic prog_start;
        logic prog_erase;
        logic prog_lock;
        logic [PAGE_SEL_W-1:0] prog_page;
        logic [7:0] lock_data;
        logic [PC_W-1:0] boot_start;
        logic irq;
    } ctl_s;
    ctl_s s_q;
    ctl_s s_d;
    logic tmr_busy;
    logic tmr_done;

    // *****************************************
    // helpers
    // *****************************************
    function automatic logic in_rww(input logic [PC_W-1:0] waddr);
        in_rww = waddr < PROTECTED_BOOT_REGION_START;
    endfunction

    function automatic logic cmd_legal(input logic [4:0] cmd);
        cmd_legal = (cmd == CMD_RESTORE) || (cmd == CMD_LOCKSET) || (cmd == CMD_PAGE_WRITE_CMD)
                    || (cmd == CMD_PAGE_ERASE_CMD) || (cmd == CMD_BUFLOAD);
    endfunction

    function automatic logic [PC_W-1:0] boot_of(input logic [1:0] sz);
        case (sz)
            2'b11: boot_of = BOOT_START_256;
            2'b10: boot_of = BOOT_START_512;
            2'b01: boot_of = BOOT_START_1024;
            default: boot_of = BOOT_START_2048;
        endcase
    endfunction

    // *****************************************
    // programming timer
    // *****************************************
    // survives system reset so an interrupted write still completes
    prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(s_q.prog_start),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    // *****************************************
    // next state
    // *****************************************
    always_comb
    begin
        logic store_armed;
        logic load_armed;
        logic [4:0] cmd;
        logic [7:0] fuse_high_rd;
        store_armed = 1'b0;
        load_armed = 1'b0;
        cmd = 5'h00;
        fuse_high_rd = 8'h00;
        s_d = s_q;
        s_d.load_valid = 1'b0;
        s_d.buf_wr = 1'b0;
        s_d.buf_clear = 1'b0;
        s_d.prog_start = 1'b0;
        fuse_high_rd = ~fuse_high_prog;
        s_d.boot_start = boot_of(fuse_high_rd[BOOTSZ_LSB +: 2]);
        cmd = s_q.ctrl[4:0];
        // window counter restarts on each accepted control write with a legal command
        store_armed = s_q.ctrl[CTRL_STORE_PROG_ENABLE] && (s_q.win != 3'h0)
                      && (s_q.win <= STORE_WIN);
        load_armed = s_q.ctrl[CTRL_STORE_PROG_ENABLE] && s_q.ctrl[CTRL_LOCKSET]
                     && (s_q.win != 3'h0) && (s_q.win <= LOAD_WIN);
        if (s_q.win != 3'h0)
        begin
            if (s_q.win == STORE_WIN)
            begin
                s_d.win = 3'h0;
                s_d.ctrl = s_q.ctrl & ~CTRL_CMD_MASK;
            end
            else
            begin
                s_d.win = s_q.win + 3'h1;
            end
        end
        if (tmr_done)
            s_d.ctrl = s_q.ctrl & ~CTRL_CMD_MASK;
        // control write; refused during eeprom write or a running operation
        if (core.ctrl_wr && !ee_write_busy && !tmr_busy && !s_q.prog_start)
        begin
            s_d.ctrl[CTRL_IE] = core.ctrl_wdata[CTRL_IE];
            if (cmd_legal(core.ctrl_wdata[4:0]))
            begin
                s_d.ctrl[4:0] = core.ctrl_wdata[4:0];
                s_d.win = 3'h1;
            end
        end
        // store instruction
        if (core.store_req && store_armed && !ee_write_busy)
        begin
            s_d.win = 3'h0;
            case (cmd)
                CMD_PAGE_ERASE_CMD, CMD_PAGE_WRITE_CMD:
                begin
                    // a store in the last window cycle must not lose the command bits
                    s_d.ctrl[4:0] = s_q.ctrl[4:0];
                    s_d.prog_start = 1'b1;
                    s_d.prog_erase = (cmd == CMD_PAGE_ERASE_CMD);
                    s_d.prog_lock = 1'b0;
                    s_d.prog_page = core.z_ptr[Z_PAGE_LSB +: PAGE_SEL_W];
                    if (core.z_ptr[Z_PAGE_LSB +: PAGE_SEL_W] < RWW_PAGES)
                        s_d.ctrl[CTRL_RWW_BUSY] = 1'b1;
                end
                CMD_LOCKSET:
                begin
                    s_d.prog_start = 1'b1;
                    s_d.ctrl[4:0] = s_q.ctrl[4:0];
                    s_d.prog_erase = 1'b0;
                    s_d.prog_lock = 1'b1;
                    s_d.lock_data = core.store_data[7:0];
                end
                CMD_RESTORE:
                begin
                    s_d.ctrl = s_q.ctrl & ~CTRL_CMD_MASK;
                    s_d.ctrl[CTRL_RWW_BUSY] = 1'b0;
                    s_d.buf_clear = 1'b1;
                end
                default:
                begin
                    s_d.ctrl = s_q.ctrl & ~CTRL_CMD_MASK;
                    s_d.ctrl[CTRL_RWW_BUSY] = 1'b0;
                    s_d.buf_wr = 1'b1;
                    s_d.buf_word = core.z_ptr[Z_WORD_LSB +: WORD_SEL_W];
                    s_d.buf_wdata = core.store_data;
                end
            endcase
        end
        // load instruction; answer two cycles later
        if (core.load_req)
        begin
            s_d.pend = 1'b1;
            s_d.from_flash = 1'b0;
            s_d.byte_hi = core.z_ptr[0];
            s_d.direct = BLOCKED_BYTE;
            if (load_armed)
            begin
                s_d.win = 3'h0;
                s_d.ctrl[CTRL_LOCKSET] = 1'b0;
                s_d.ctrl[CTRL_STORE_PROG_ENABLE] = 1'b0;
                if (!ee_write_busy)
                begin
                    case (core.z_ptr[14:0])
                        Z_LOCK: s_d.direct = ~lock_prog;
                        Z_FUSE_LOW: s_d.direct = ~fuse_low_prog;
                        Z_FUSE_HIGH: s_d.direct = fuse_high_rd;
                        default: s_d.direct = BLOCKED_BYTE;
                    endcase
                end
            end
            else if (!(s_q.ctrl[CTRL_RWW_BUSY] && in_rww(core.z_ptr[14:1])))
            begin
                s_d.from_flash = 1'b1;
                s_d.raddr = core.z_ptr[14:1];
            end
        end
        if (s_q.pend && !core.load_req)
            s_d.pend = 1'b0;
        if (s_q.pend)
        begin
            s_d.load_valid = 1'b1;
            if (!s_q.from_flash)
                s_d.load_data = s_q.direct;
            else if (s_q.byte_hi)
                s_d.load_data = flash_rdata[15:8];
            else
                s_d.load_data = flash_rdata[7:0];
        end
        // system reset clears software state but keeps a running write alive
        if (core.sys_reset)
        begin
            s_d.ctrl = CTRL_RESET;
            s_d.ctrl[CTRL_STORE_PROG_ENABLE] = tmr_busy || s_q.prog_start;
            s_d.ctrl[CTRL_RWW_BUSY] = s_q.ctrl[CTRL_RWW_BUSY];
            s_d.win = 3'h0;
            s_d.pend = 1'b0;
            s_d.load_valid = 1'b0;
            s_d.buf_wr = 1'b0;
            s_d.buf_clear = 1'b1;
        end
        s_d.irq = s_d.ctrl[CTRL_IE] && !s_d.ctrl[CTRL_STORE_PROG_ENABLE];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // *****************************************
    // outputs
    // *****************************************
    assign core.ctrl_rdata = s_q.ctrl;
    assign core.load_data = s_q.load_data;
    assign core.load_valid = s_q.load_valid;
    assign flash_raddr = s_q.raddr;
    assign buf_wr = s_q.buf_wr;
    assign buf_word = s_q.buf_word;
    assign buf_wdata = s_q.buf_wdata;
    assign buf_clear = s_q.buf_clear;
    assign prog_start = s_q.prog_start;
    assign prog_erase = s_q.prog_erase;
    assign prog_lock = s_q.prog_lock;
    assign prog_page = s_q.prog_page;
    assign prog_lock_data = s_q.lock_data;
    assign prog_busy = tmr_busy;
    assign region_busy = s_q.ctrl[CTRL_RWW_BUSY];
    assign boot_start = s_q.boot_start;
    assign ready_irq = s_q.irq;
endmodule
`default_nettype wire

// ### hdl/spm_pkg.sv
// shared constants for the flash self-programming controller and its core-side host
package spm_pkg;
    // control register bit positions
    localparam int CTRL_IE = 7;
    localparam int CTRL_RWW_BUSY = 6;
    localparam int CTRL_RESTORE = 4;
    localparam int CTRL_LOCKSET = 3;
    localparam int CTRL_PAGE_WRITE_CMD = 2;
    localparam int CTRL_PAGE_ERASE_CMD = 1;
    localparam int CTRL_STORE_PROG_ENABLE = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_CMD_MASK = 8'h1f;
    localparam logic [4:0] CMD_RESTORE = 5'h11;
    localparam logic [4:0] CMD_LOCKSET = 5'h09;
    localparam logic [4:0] CMD_PAGE_WRITE_CMD = 5'h05;
    localparam logic [4:0] CMD_PAGE_ERASE_CMD = 5'h03;
    localparam logic [4:0] CMD_BUFLOAD = 5'h01;
    // arming windows in cycles after the control write
    localparam logic [2:0] LOAD_WIN = 3'h3;
    localparam logic [2:0] STORE_WIN = 3'h4;
    // pointer selections for fuse and lock reads, bit 15 ignored
    localparam logic [14:0] Z_FUSE_LOW = 15'h0000;
    localparam logic [14:0] Z_LOCK = 15'h0001;
    localparam logic [14:0] Z_FUSE_HIGH = 15'h0003;
    localparam logic [7:0] BLOCKED_BYTE = 8'hff;
    // flash geometry
    localparam int PC_W = 14;
    localparam int WORD_SEL_W = 6;
    localparam int PAGE_SEL_W = 8;
    localparam int Z_PAGE_LSB = 7;
    localparam int Z_WORD_LSB = 1;
    localparam logic [13:0] PROTECTED_BOOT_REGION_START = 14'h3800;
    localparam logic [7:0] RWW_PAGES = 8'd224;
    localparam int PROTECTED_BOOT_REGION_PAGES = 32;
    localparam int BOOTSZ_LSB = 1;
    localparam logic [13:0] BOOT_START_256 = 14'h3f00;
    localparam logic [13:0] BOOT_START_512 = 14'h3e00;
    localparam logic [13:0] BOOT_START_1024 = 14'h3c00;
    localparam logic [13:0] BOOT_START_2048 = 14'h3800;
    // programming time
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_MIN_NS = 3700000;
    localparam int PROG_MAX_NS = 4500000;
    localparam int PROG_MIN_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_MAX_CYCLES = PROG_MAX_NS / CLK_PERIOD_NS;
    // host apb map
    localparam logic [7:0] ADDR_ZPTR = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic [7:0] ADDR_SYSRST = 8'h14;
    localparam int CMD_OP_LSB = 8;
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_STORE = 2'h1;
    localparam logic [1:0] OP_LOAD = 2'h2;
endpackage

// ### hdl/spm_if.sv
// core-to-flash-controller program-memory instruction port
`timescale 1ns/1ps
`default_nettype none
interface spm_if;
    logic ctrl_wr;
    logic [7:0] ctrl_wdata;
    logic [7:0] ctrl_rdata;
    logic store_req;
    logic load_req;
    logic [15:0] z_ptr;
    logic [15:0] store_data;
    logic [7:0] load_data;
    logic load_valid;
    logic sys_reset;
    modport core (output ctrl_wr, output ctrl_wdata, output store_req, output load_req,
                  output z_ptr, output store_data, output sys_reset,
                  input ctrl_rdata, input load_data, input load_valid);
    modport flash (input ctrl_wr, input ctrl_wdata, input store_req, input load_req,
                   input z_ptr, input store_data, input sys_reset,
                   output ctrl_rdata, output load_data, output load_valid);
endinterface
`default_nettype wire

// ### hdl/prog_timer.sv
// programming duration timer, cleared only by power-on reset
`timescale 1ns/1ps
`default_nettype none
module prog_timer
    import spm_pkg::*;
#(
    parameter int CYCLES = PROG_MIN_CYCLES
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [23:0] cnt;
        logic busy;
        logic done;
    } tmr_s;
    tmr_s s_q;
    tmr_s s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (s_q.busy)
        begin
            if (s_q.cnt == 24'(CYCLES - 1))
            begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            else
            begin
                s_d.cnt = s_q.cnt + 24'h000001;
            end
        end
        else if (start)
        begin
            s_d.busy = 1'b1;
            s_d.cnt = 24'h000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule
`default_nettype wire

// ### hdl/spm_host.sv
// core-side sequencer: apb registers drive timed program-memory instructions
`timescale 1ns/1ps
`default_nettype none
module spm_host
    import spm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ee_write_busy,
    spm_if.core core
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CTRL, ST_OP} host_e;
    typedef struct packed {
        host_e st;
        logic [15:0] z;
        logic [15:0] data;
        logic [7:0] cmd_ctrl;
        logic [1:0] cmd_op;
        logic [7:0] result;
        logic done;
        logic ctrl_wr;
        logic store_req;
        logic load_req;
        logic sys_reset;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } host_s;
    host_s s_q;
    host_s s_d;

    always_comb
    begin
        logic setup;
        logic wr;
        setup = psel && !penable;
        // writes land at the edge where the master samples pready high
        wr = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
        s_d = s_q;
        s_d.ctrl_wr = 1'b0;
        s_d.store_req = 1'b0;
        s_d.load_req = 1'b0;
        s_d.sys_reset = 1'b0;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        if (core.load_valid)
        begin
            s_d.result = core.load_data;
            s_d.done = 1'b1;
        end
        // apb: decode in setup, answer in the first access cycle
        if (setup)
        begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h00000000;
            case (paddr)
                ADDR_ZPTR: s_d.prdata = {16'h0000, s_q.z};
                ADDR_DATA: s_d.prdata = {16'h0000, s_q.data};
                ADDR_CMD: s_d.prdata = {22'h000000, s_q.cmd_op, s_q.cmd_ctrl};
                ADDR_STATUS: s_d.prdata = {22'h000000, s_q.st != ST_IDLE, s_q.done,
                                           core.ctrl_rdata};
                ADDR_RESULT: s_d.prdata = {24'h000000, s_q.result};
                ADDR_SYSRST: s_d.prdata = 32'h00000000;
                default: s_d.pslverr = 1'b1;
            endcase
            // a command while one is pending is refused with an error
            if (pwrite && paddr == ADDR_CMD && s_q.st != ST_IDLE)
                s_d.pslverr = 1'b1;
        end
        if (wr && paddr == ADDR_ZPTR)
            s_d.z = pwdata[15:0];
        if (wr && paddr == ADDR_DATA)
            s_d.data = pwdata[15:0];
        if (wr && paddr == ADDR_SYSRST)
            s_d.sys_reset = pwdata[0];
        if (wr && paddr == ADDR_CMD)
        begin
            s_d.cmd_ctrl = pwdata[7:0];
            s_d.cmd_op = pwdata[CMD_OP_LSB +: 2];
            s_d.done = 1'b0;
            s_d.st = ST_WAIT;
        end
        case (s_q.st)
            ST_IDLE:
            begin
            end
            ST_WAIT:
            begin
                // previous store finished and no eeprom write in flight
                if (!core.ctrl_rdata[CTRL_STORE_PROG_ENABLE] && !ee_write_busy)
                begin
                    s_d.ctrl_wr = 1'b1;
                    s_d.st = ST_CTRL;
                    if (s_q.cmd_ctrl[CTRL_PAGE_WRITE_CMD])
                        s_d.z[Z_WORD_LSB +: WORD_SEL_W] = '0;
                    if (s_q.cmd_op == OP_STORE)
                        s_d.z[0] = 1'b0;
                end
            end
            ST_CTRL:
            begin
                s_d.st = ST_OP;
                s_d.store_req = (s_q.cmd_op == OP_STORE);
                s_d.load_req = (s_q.cmd_op == OP_LOAD);
                if (s_q.cmd_op != OP_LOAD)
                    s_d.done = 1'b1;
            end
            ST_OP:
            begin
                if (s_q.cmd_op != OP_LOAD || core.load_valid)
                    s_d.st = ST_IDLE;
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign core.ctrl_wr = s_q.ctrl_wr;
    assign core.ctrl_wdata = s_q.cmd_ctrl;
    assign core.store_req = s_q.store_req;
    assign core.load_req = s_q.load_req;
    assign core.z_ptr = s_q.z;
    assign core.store_data = s_q.data;
    assign core.sys_reset = s_q.sys_reset;
endmodule
`default_nettype wire

// ### verification/spm_asserts.sv
// concurrent checks on the program-memory instruction port
`timescale 1ns/1ps
`default_nettype none
module spm_asserts
    import spm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [7:0] ctrl_rdata,
    input wire logic store_req,
    input wire logic load_req,
    input wire logic [15:0] z_ptr,
    input wire logic load_valid
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****************
    // sequences
    // ****************
    sequence cmd_s(c);
        ctrl_wr && ctrl_wdata[4:0] == c;
    endsequence
    sequence idle4_s;
        (!store_req && !load_req) [*4];
    endsequence
    a_load_answer: assert property (load_req |-> ##2 load_valid)
        else $error("load gave no answer");
    a_valid_cause: assert property (load_valid |-> $past(load_req, 2))
        else $error("answer without a load");
    a_arm_seen: assert property (cmd_s(CMD_LOCKSET) |=> ctrl_rdata[3:0] == 4'h9)
        else $error("lock arming not shown");
    a_lock_clear: assert property (
        cmd_s(CMD_LOCKSET) ##1 load_req |-> ##[1:3] ctrl_rdata[3:0] == 4'h0)
        else $error("arming kept after load");
    a_arm_expiry: assert property (
        cmd_s(CMD_LOCKSET) ##1 idle4_s |=> ctrl_rdata[3:0] == 4'h0)
        else $error("arming outlived window");
    a_busy_set: assert property (
        cmd_s(CMD_PAGE_ERASE_CMD) ##1 (store_req && ctrl_rdata[1:0] == 2'b11 && z_ptr[14:7] < 8'd224)
        |-> ##[1:2] ctrl_rdata[6])
        else $error("region busy not set");
    a_busy_clear: assert property (
        cmd_s(CMD_RESTORE) ##1 (store_req && ctrl_rdata[4]) |-> ##[1:2] !ctrl_rdata[6])
        else $error("region busy not cleared");
    a_reserved_bit: assert property (!ctrl_rdata[5])
        else $error("reserved bit set");
endmodule
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench joining the host sequencer to the flash controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import spm_pkg::*;
    typedef struct packed {logic [15:0] z; logic [31:0] cmd; logic [7:0] exp;} row_s;
    row_s rows [6];
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic ee_busy = 1'b0;
    logic ee_hide = 1'b0;
    localparam int TB_PROG = 40;
    int busy_len = 0;
    int last_len = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, prog_busy;
    logic [13:0] flash_raddr, boot_start;
    logic [7:0] prog_page;
    int n_errors = 0;
    int n_compared = 0;
    int k, j;
    // flash content derived from the address so every word differs
    wire logic [15:0] flash_rdata = {2'h0, flash_raddr} ^ 16'ha5a5;
    spm_if link ();
    always #2 pclk = ~pclk;
    // length of each programming run in cycles
    always @(posedge pclk)
    begin
        if (prog_busy)
            busy_len <= busy_len + 1;
        else if (busy_len != 0)
        begin
            last_len <= busy_len;
            busy_len <= 0;
        end
    end
    spm_host spm_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(), .ee_write_busy(ee_busy && !ee_hide), .core(link));
    // short programming time keeps the run brief
    flash_self_program_ctrl #(.PROG_CYCLES(TB_PROG)) flash_self_program_ctrl_i (.pclk(pclk),
        .presetn(presetn), .core(link), .ee_write_busy(ee_busy), .fuse_low_prog(8'h3c),
        .fuse_high_prog(8'h81), .lock_prog(8'h0f), .flash_raddr(flash_raddr),
        .flash_rdata(flash_rdata), .buf_wr(), .buf_word(), .buf_wdata(), .buf_clear(),
        .prog_start(), .prog_erase(), .prog_lock(), .prog_page(prog_page), .prog_lock_data(),
        .prog_busy(prog_busy), .region_busy(), .boot_start(boot_start), .ready_irq());
    spm_asserts spm_asserts_i (.pclk(pclk), .presetn(presetn), .ctrl_wr(link.ctrl_wr),
        .ctrl_wdata(link.ctrl_wdata), .ctrl_rdata(link.ctrl_rdata), .store_req(link.store_req),
        .load_req(link.load_req), .z_ptr(link.z_ptr), .load_valid(link.load_valid));
    // ****************
    // tasks
    // ****************
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        n_errors++;
        $display("MISMATCH t=%0t wait ran out", $time);
        tally_and_finish();
    endtask
    // entered just after a rising edge; request held until pready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (k >= 20)
            hang();
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // polls until the host is idle and no store is armed or running
    task automatic settle();
        j = 0;
        do
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            j++;
        end
        while ((rd[9] !== 1'b0 || rd[0] !== 1'b0) && j < 200);
        if (j >= 200)
            hang();
    endtask
    task automatic load(input logic [15:0] z, input logic [31:0] cmd);
        apb(1'b1, ADDR_ZPTR, {16'h0, z});
        apb(1'b1, ADDR_CMD, cmd);
        settle();
        apb(1'b0, ADDR_RESULT, 32'h0);
    endtask
    task automatic wait_prog();
        j = 0;
        while (prog_busy !== 1'b1 && j < 100)
        begin
            @(posedge pclk);
            j++;
        end
        if (j >= 100)
            hang();
    endtask
    // ****************
    // sequence
    // ****************
    initial
    begin
        rows = '{'{16'h0000, 32'h209, 8'hc3}, '{16'h0001, 32'h209, 8'hf0},
            '{16'h0003, 32'h209, 8'h7e}, '{16'h0005, 32'h209, 8'hff},
            '{16'hc103, 32'h200, 8'h85}, '{16'hc102, 32'h200, 8'h24}};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, 32'h00000000);
        foreach (rows[i])
        begin
            load(rows[i].z, rows[i].cmd);
            check(rd[7:0], rows[i].exp);
        end
        check(boot_start, BOOT_START_256);
        $display("fuse, lock and plain loads done");
        apb(1'b1, ADDR_CMD, 32'h009);
        settle();
        check(rd[7:0], 8'h00);
        $display("window expiry done");
        apb(1'b1, ADDR_ZPTR, 32'h0180);
        apb(1'b1, ADDR_CMD, 32'h103);
        wait_prog();
        check(prog_page, 8'h03);
        apb(1'b1, ADDR_SYSRST, 32'h1);
        check(prog_busy, 1'b1);
        settle();
        check(rd[6], 1'b1);
        check(rd[0], 1'b0);
        check(last_len, TB_PROG);
        apb(1'b1, ADDR_CMD, 32'h111);
        settle();
        check(rd[6], 1'b0);
        $display("erase, system reset and restore done");
        ee_busy <= 1'b1;
        apb(1'b1, ADDR_CMD, 32'h103);
        repeat (3) apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd[9], 1'b1);
        check(prog_busy, 1'b0);
        ee_busy <= 1'b0;
        wait_prog();
        load(16'hc102, 32'h200);
        check(rd[7:0], 8'hff);
        // host is told the eeprom is idle so the controller's own interlock is seen
        ee_hide <= 1'b1;
        apb(1'b1, ADDR_ZPTR, 32'h0001);
        apb(1'b1, ADDR_CMD, 32'h209);
        k = 0;
        while (link.ctrl_wr !== 1'b1 && k < 20)
        begin
            @(posedge pclk);
            k++;
        end
        if (k >= 20)
            hang();
        ee_busy <= 1'b1;
        settle();
        apb(1'b0, ADDR_RESULT, 32'h0);
        check(rd[7:0], BLOCKED_BYTE);
        apb(1'b1, ADDR_CMD, 32'h183);
        settle();
        check(rd[7:0], 8'h40);
        check(prog_busy, 1'b0);
        ee_busy <= 1'b0;
        ee_hide <= 1'b0;
        $display("eeprom interlock and blocked region done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
